// >>> hw/apmeb_pkg.sv
package apmeb_pkg;
  // host-side block offsets
  localparam logic [2:0] OFS_STATUS_LOW = 3'h0;
  localparam logic [2:0] OFS_STATUS_HIGH = 3'h1;
  localparam logic [2:0] OFS_ENABLE_LOW = 3'h2;
  localparam logic [2:0] OFS_ENABLE_HIGH = 3'h3;
  localparam logic [2:0] OFS_CONTROL_LOW = 3'h4;
  localparam logic [2:0] OFS_CONTROL_HIGH = 3'h5;
  // configuration indices
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_UPPER = 8'h60;
  localparam logic [7:0] IDX_BASE_LOWER = 8'h61;
  // controller-side addresses (low byte of the controller map)
  localparam logic [1:0] MC_STATUS = 2'h0;
  localparam logic [1:0] MC_ENABLE = 2'h1;
  localparam logic [1:0] MC_CONTROL = 2'h2;
  // status and control field positions
  localparam int BIT_POWER_BUTTON = 0;
  localparam int BIT_SLEEP_BUTTON = 1;
  localparam int BIT_ALARM = 2;
  localparam int BIT_OVERRIDE = 3;
  localparam int BIT_WAKE = 7;
  localparam int BIT_SLEEP_GO = 5;
  // writable masks and the all-zero reset value
  localparam logic [7:0] STATUS_MASK = 8'h8F;
  localparam logic [7:0] ENABLE_MASK = 8'h07;
  localparam logic [7:0] CONTROL_MASK = 8'h1E;
  localparam logic [7:0] RESET_ZERO = 8'h00;
endpackage

// >>> hw/apmeb_cfg_if.sv
`timescale 1ns/10ps
interface apmeb_cfg_if;
  logic decode_on;
  logic [11:0] base_addr;
  modport cfg (output decode_on, output base_addr);
  modport core (input decode_on, input base_addr);
endinterface

// >>> hw/apmeb_cfg_regs.sv
`timescale 1ns/10ps
module apmeb_cfg_regs
  import apmeb_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic cfg_reset_n_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] cfg_index_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  apmeb_cfg_if.cfg cfg
);
  logic activate;
  logic [3:0] base_upper;
  logic [4:0] base_lower;
  wire wr_act = cfg_wr_in && (cfg_index_in == IDX_ACTIVATE);
  wire wr_up = cfg_wr_in && (cfg_index_in == IDX_BASE_UPPER);
  wire wr_lo = cfg_wr_in && (cfg_index_in == IDX_BASE_LOWER);
  ////////////////////////////////////////////////////////////////////////
  // config reset is the non-main reset; main supply reset leaves these alone
  always_ff @(posedge core_clk_in) begin
    if (!cfg_reset_n_in) begin
      activate <= 1'b0; // [R21]
      base_upper <= 4'h0;
      base_lower <= 5'h00;
    end else begin
      if (wr_act) activate <= cfg_wdata_in[0];
      if (wr_up) base_upper <= cfg_wdata_in[3:0]; // [R20]
      if (wr_lo) base_lower <= cfg_wdata_in[7:3]; // [R13] low bits forced zero
    end
  end
  // readback, unused bits zero
  always_comb begin
    cfg_rdata_out = RESET_ZERO;
    if (cfg_index_in == IDX_ACTIVATE) cfg_rdata_out = {7'h00, activate};
    if (cfg_index_in == IDX_BASE_UPPER) cfg_rdata_out = {4'h0, base_upper};
    if (cfg_index_in == IDX_BASE_LOWER) cfg_rdata_out = {base_lower, 3'h0};
  end
  assign cfg.decode_on = activate;
  assign cfg.base_addr = {base_upper, base_lower, 3'h0}; // [R13]
endmodule

// >>> hw/apmeb_top.sv
`timescale 1ns/10ps
// How it works
// [R1] controller sets and clears sleep button flag
// [R2] host writes sleep enable; controller reads only
// [R3] controller writes status, only reads enables
// [R4] alarm gives wake-up and optional interrupt
// [R5] clock alarm sets flag; host enables it
// [R6] host write one clears, zero keeps
// [R7] main supply reset clears all status
// [R8] status set only by event or controller
// [R9] interrupt request only while enable set
// [R10] disabled event still sets status flag
// [R11] enable bit matches status position
// [R12] decode only while activate bit set
// [R13] base 12 bits, 8-byte aligned, below 0x1000
// [R14] eight bytes: status, enable, control, reserved
// [R15] block state lives on main supply reset
// [R16] status high byte layout, bits 4-6 zero
// [R17] enable high byte bits 0-2, rest zero
// [R18] host write to high bytes interrupts controller
// [R19] sleep go: host sets, controller clears
// [R20] index 0x60 upper bits, 0x61 lower bits
// [R21] config regs reset by secondary resets only
module apmeb_top
  import apmeb_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic cfg_reset_n_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] cfg_index_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  input wire logic io_rd_in,
  input wire logic io_wr_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  output logic io_hit_out,
  input wire logic mc_wr_in,
  input wire logic [1:0] mc_addr_in,
  input wire logic [7:0] mc_wdata_in,
  output logic [7:0] mc_rdata_out,
  input wire logic alarm_event_in,
  output logic controller_interrupt_out,
  output logic host_write_irq_out,
  output logic alarm_wake_out,
  output logic [2:0] sleep_kind_out,
  output logic sleep_go_out,
  output logic override_allow_out
);
  ////////////////////////////////////////////////////////////////////////
  // configuration side
  apmeb_cfg_if cfg_bus ();
  logic [7:0] cfg_rdata;
  apmeb_cfg_regs u_cfg (
    .core_clk_in(core_clk_in),
    .cfg_reset_n_in(cfg_reset_n_in),
    .cfg_wr_in(cfg_wr_in),
    .cfg_index_in(cfg_index_in),
    .cfg_wdata_in(cfg_wdata_in),
    .cfg_rdata_out(cfg_rdata),
    .cfg(cfg_bus.cfg)
  );
  ////////////////////////////////////////////////////////////////////////
  // state, all on the main supply reset
  logic [7:0] status;
  logic [7:0] enable;
  logic [7:0] control;
  logic [7:0] next_status;
  logic [7:0] next_control;
  // host decode
  wire in_block = cfg_bus.decode_on // [R12]
    && (io_addr_in[15:3] == {1'b0, cfg_bus.base_addr[11:3]}); // [R13]
  wire [2:0] ofs = io_addr_in[2:0]; // [R14]
  wire host_wr = io_wr_in && in_block;
  wire hw_status = host_wr && (ofs == OFS_STATUS_HIGH);
  wire hw_enable = host_wr && (ofs == OFS_ENABLE_HIGH);
  wire hw_control = host_wr && (ofs == OFS_CONTROL_HIGH);
  wire mw_status = mc_wr_in && (mc_addr_in == MC_STATUS); // [R3]
  wire mw_control = mc_wr_in && (mc_addr_in == MC_CONTROL);
  wire [7:0] ev_set = alarm_event_in ? (8'h01 << BIT_ALARM) : 8'h00; // [R5]
  ////////////////////////////////////////////////////////////////////////
  // status: controller write, host write-one-clear, then event sets win
  always_comb begin
    next_status = status;
    if (mw_status) next_status = mc_wdata_in & STATUS_MASK; // [R1] [R3]
    if (hw_status) next_status = next_status & ~io_wdata_in; // [R6]
    next_status = (next_status | ev_set) & STATUS_MASK; // [R8] [R10] [R16]
  end
  // control: host writes type bits and may only set sleep go
  always_comb begin
    next_control = control;
    if (hw_control) begin
      next_control = (io_wdata_in & CONTROL_MASK) | (control & ~CONTROL_MASK);
      next_control[BIT_SLEEP_GO] = control[BIT_SLEEP_GO] | io_wdata_in[BIT_SLEEP_GO]; // [R19]
    end
    if (mw_control && mc_wdata_in[BIT_SLEEP_GO] && !io_wdata_in[BIT_SLEEP_GO]) begin
      next_control[BIT_SLEEP_GO] = 1'b0; // [R19] host set wins a same-cycle clear
    end
    if (mw_control && mc_wdata_in[BIT_SLEEP_GO] && !hw_control) begin
      next_control[BIT_SLEEP_GO] = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // registers; kept on the main supply reset so they survive the secondary
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      status <= RESET_ZERO; // [R7] [R15]
      enable <= RESET_ZERO;
      control <= RESET_ZERO;
    end else begin
      status <= next_status;
      if (hw_enable) enable <= io_wdata_in & ENABLE_MASK; // [R2] [R11] [R17]
      control <= next_control;
    end
  end
  // host read data, reserved bytes and bits zero, sleep go hidden
  wire [7:0] host_rd_mux =
    (ofs == OFS_STATUS_HIGH) ? status :
    (ofs == OFS_ENABLE_HIGH) ? enable :
    (ofs == OFS_CONTROL_HIGH) ? (control & CONTROL_MASK) : // [R19]
    RESET_ZERO; // [R14]
  wire [7:0] mc_rd_mux =
    (mc_addr_in == MC_STATUS) ? status :
    (mc_addr_in == MC_ENABLE) ? enable :
    (mc_addr_in == MC_CONTROL) ? control : RESET_ZERO;
  wire [7:0] pending = next_status & enable; // [R9] [R11]
  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      io_rdata_out <= RESET_ZERO;
      io_hit_out <= 1'b0;
      mc_rdata_out <= RESET_ZERO;
      cfg_rdata_out <= RESET_ZERO;
      controller_interrupt_out <= 1'b0;
      host_write_irq_out <= 1'b0;
      alarm_wake_out <= 1'b0;
      sleep_kind_out <= 3'h0;
      sleep_go_out <= 1'b0;
      override_allow_out <= 1'b0;
    end else begin
      io_rdata_out <= (io_rd_in && in_block) ? host_rd_mux : RESET_ZERO;
      io_hit_out <= (io_rd_in || io_wr_in) && in_block; // [R12]
      mc_rdata_out <= mc_rd_mux;
      cfg_rdata_out <= cfg_rdata;
      controller_interrupt_out <= |pending[2:0]; // [R9] [R10]
      host_write_irq_out <= hw_status || hw_enable || hw_control; // [R18]
      alarm_wake_out <= next_status[BIT_ALARM]; // [R4] wake regardless of enable
      sleep_kind_out <= next_control[4:2];
      sleep_go_out <= next_control[BIT_SLEEP_GO];
      override_allow_out <= next_control[1];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // checks
  a_status_w1c_clear: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    hw_status && io_wdata_in[BIT_SLEEP_BUTTON] && !mw_status
    |=> !status[BIT_SLEEP_BUTTON]) // [R6]
    else $error("host write one did not clear flag");
  a_status_w0_keep: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    hw_status && !io_wdata_in[BIT_POWER_BUTTON] && !mw_status && status[BIT_POWER_BUTTON]
    |=> status[BIT_POWER_BUTTON]) // [R6]
    else $error("host write zero changed flag");
  a_alarm_sets_flag: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    alarm_event_in |=> status[BIT_ALARM] && alarm_wake_out) // [R5]
    else $error("alarm did not set flag and wake");
  a_no_spurious_set: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !mw_status && !alarm_event_in |=> (status & ~$past(status)) == 8'h00) // [R8]
    else $error("status set without a cause");
  a_irq_needs_enable: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    ##1 controller_interrupt_out |-> |($past(next_status[2:0]) & $past(enable[2:0]))) // [R9]
    else $error("interrupt without enabled flag");
  a_decode_off: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !cfg_bus.decode_on |=> !io_hit_out) // [R12]
    else $error("block answered while inactive");
  a_sleep_go_hidden: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    io_rd_in && in_block && ofs == OFS_CONTROL_HIGH |=> !io_rdata_out[BIT_SLEEP_GO]) // [R19]
    else $error("sleep go visible to host");
  a_sleep_go_sticky: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    control[BIT_SLEEP_GO] && !mw_control |=> control[BIT_SLEEP_GO]) // [R19]
    else $error("sleep go cleared without controller");
  a_host_write_irq: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    hw_enable |=> host_write_irq_out && enable == ($past(io_wdata_in) & ENABLE_MASK)) // [R18]
    else $error("enable write missing interrupt or value");
  a_enable_reserved: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    enable[7:3] == 5'h00) // [R17]
    else $error("reserved enable bits set");
endmodule

// >>> tb/apmeb_mc_model.sv
`timescale 1ns/10ps
module apmeb_mc_model (
  input wire logic core_clk_in,
  input wire logic [7:0] mc_rdata_in,
  output logic mc_wr_out,
  output logic [1:0] mc_addr_out,
  output logic [7:0] mc_wdata_out,
  output logic alarm_event_out
);
  // idle values; the data bus never keeps showing a released value
  initial begin
    mc_wr_out = 1'b0;
    mc_addr_out = 2'h3;
    mc_wdata_out = 8'h5A;
    alarm_event_out = 1'b0;
  end
  // controller write, one cycle between falling edges
  task automatic mc_write(input logic [1:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    mc_wr_out = 1'b1;
    mc_addr_out = a;
    mc_wdata_out = d;
    @(negedge core_clk_in);
    mc_wr_out = 1'b0;
    mc_wdata_out = ~d;
  endtask
  // controller read, one cycle of latency
  task automatic mc_read(input logic [1:0] a, output logic [7:0] d);
    @(negedge core_clk_in);
    mc_addr_out = a;
    @(negedge core_clk_in);
    d = mc_rdata_in;
  endtask
  // clock alarm reported as a one-cycle pulse
  task automatic alarm_pulse();
    @(negedge core_clk_in);
    alarm_event_out = 1'b1;
    @(negedge core_clk_in);
    alarm_event_out = 1'b0;
  endtask
endmodule

// >>> tb/apmeb_top_tb.sv
`timescale 1ns/10ps
module apmeb_top_tb;
  import apmeb_pkg::*;
  localparam logic [15:0] B = 16'h0A48;
  logic core_clk_in, reset_n_in, cfg_reset_n_in, cfg_wr_in, io_rd_in, io_wr_in;
  logic [7:0] cfg_index_in, cfg_wdata_in, cfg_rdata_out, io_wdata_in, io_rdata_out;
  logic [7:0] mc_wdata_in, mc_rdata_out, q;
  logic [15:0] io_addr_in;
  logic [1:0] mc_addr_in;
  logic [2:0] sleep_kind_out;
  logic io_hit_out, mc_wr_in, alarm_event_in, controller_interrupt_out;
  logic host_write_irq_out, alarm_wake_out, sleep_go_out, override_allow_out;
  int n_mismatch, compares;
  apmeb_top i_dut (.core_clk_in, .reset_n_in, .cfg_reset_n_in, .cfg_wr_in, .cfg_index_in,
    .cfg_wdata_in, .cfg_rdata_out, .io_rd_in, .io_wr_in, .io_addr_in, .io_wdata_in,
    .io_rdata_out, .io_hit_out, .mc_wr_in, .mc_addr_in, .mc_wdata_in, .mc_rdata_out,
    .alarm_event_in, .controller_interrupt_out, .host_write_irq_out, .alarm_wake_out,
    .sleep_kind_out, .sleep_go_out, .override_allow_out);
  apmeb_mc_model i_mc (.core_clk_in, .mc_rdata_in(mc_rdata_out), .mc_wr_out(mc_wr_in),
    .mc_addr_out(mc_addr_in), .mc_wdata_out(mc_wdata_in), .alarm_event_out(alarm_event_in));
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // host cycle; strobe stands for exactly one rising edge
  task automatic hio(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    io_wr_in = w;
    io_rd_in = ~w;
    io_addr_in = a;
    io_wdata_in = d;
    @(negedge core_clk_in);
    io_wr_in = 1'b0;
    io_rd_in = 1'b0;
    io_wdata_in = ~d;
  endtask
  task automatic hr(input logic [15:0] a, input logic [7:0] e, input logic eh);
    hio(1'b0, a, 8'h00);
    chk(io_rdata_out, e);
    chk({7'h00, io_hit_out}, {7'h00, eh});
  endtask
  task automatic cw(input logic [7:0] i, input logic [7:0] d);
    @(negedge core_clk_in);
    cfg_wr_in = 1'b1;
    cfg_index_in = i;
    cfg_wdata_in = d;
    @(negedge core_clk_in);
    cfg_wr_in = 1'b0;
  endtask
  // interrupt is registered, so look one cycle after the cause
  task automatic irq(input logic e);
    @(negedge core_clk_in);
    chk({7'h00, controller_interrupt_out}, {7'h00, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n_in, cfg_reset_n_in, cfg_wr_in, io_rd_in, io_wr_in} = 5'h00;
    cfg_index_in = 8'h00;
    cfg_wdata_in = 8'h00;
    io_addr_in = 16'h0000;
    io_wdata_in = 8'h00;
    n_mismatch = 0;
    compares = 0;
    repeat (16) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    cfg_reset_n_in = 1'b1;
    // decode is off until activated; base low bits are forced to zero
    hr(B + 16'h0001, 8'h00, 1'b0);
    cw(IDX_BASE_UPPER, 8'hFA);
    cw(IDX_BASE_LOWER, 8'h4F);
    cw(IDX_ACTIVATE, 8'h01);
    @(negedge core_clk_in);
    cfg_index_in = IDX_BASE_LOWER;
    @(negedge core_clk_in);
    chk(cfg_rdata_out, 8'h48);
    for (int k = 0; k < 8; k++) begin
      hr(B + 16'(k), 8'h00, 1'b1);
    end
    hr(B + 16'h0008, 8'h00, 1'b0);
    $display("test decode done");
    // sleep button: flag without enable, then enable, then host clear
    i_mc.mc_write(MC_STATUS, 8'h02);
    irq(1'b0);
    hr(B + 16'h0001, 8'h02, 1'b1);
    hio(1'b1, B + 16'h0003, 8'h02);
    chk({7'h00, host_write_irq_out}, 8'h01);
    irq(1'b1);
    i_mc.mc_write(MC_ENABLE, 8'h00);
    i_mc.mc_read(MC_ENABLE, q);
    chk(q, 8'h02);
    hio(1'b1, B + 16'h0001, 8'h00);
    hr(B + 16'h0001, 8'h02, 1'b1);
    hio(1'b1, B + 16'h0001, 8'h02);
    irq(1'b0);
    $display("test sleep button done");
    // alarm: wake level ignores enable; enable byte keeps three bits
    i_mc.alarm_pulse();
    irq(1'b0);
    chk({7'h00, alarm_wake_out}, 8'h01);
    hr(B + 16'h0001, 8'h04, 1'b1);
    hio(1'b1, B + 16'h0003, 8'hFF);
    irq(1'b1);
    hr(B + 16'h0003, 8'h07, 1'b1);
    i_mc.mc_write(MC_STATUS, 8'hFF);
    hr(B + 16'h0001, 8'h8F, 1'b1);
    hio(1'b1, B + 16'h0001, 8'hFF);
    hr(B + 16'h0001, 8'h00, 1'b1);
    $display("test alarm done");
    // sleep go: host sets only, hidden from host, controller clears
    hio(1'b1, B + 16'h0005, 8'h3E);
    irq(1'b0);
    chk({7'h00, sleep_go_out}, 8'h01);
    chk({5'h00, sleep_kind_out}, 8'h07);
    chk({7'h00, override_allow_out}, 8'h01);
    hr(B + 16'h0005, 8'h1E, 1'b1);
    hio(1'b1, B + 16'h0005, 8'h00);
    i_mc.mc_read(MC_CONTROL, q);
    chk(q, 8'h20);
    i_mc.mc_write(MC_CONTROL, 8'h20);
    i_mc.mc_read(MC_CONTROL, q);
    chk(q, 8'h00);
    $display("test control done");
    // main reset clears status but keeps decode; config reset stops it
    i_mc.mc_write(MC_STATUS, 8'h81);
    reset_n_in = 1'b0;
    @(negedge core_clk_in);
    reset_n_in = 1'b1;
    hr(B + 16'h0001, 8'h00, 1'b1);
    cfg_reset_n_in = 1'b0;
    @(negedge core_clk_in);
    cfg_reset_n_in = 1'b1;
    hr(B + 16'h0001, 8'h00, 1'b0);
    $display("test resets done");
    close_out();
  end
endmodule
